// file: pkg/framer_pkg.sv
// Shared constants and carrier types of the serial packet framer
package framer_pkg;
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          MS_NS         = 1000000;
  localparam int          MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int          BUF_BYTES     = 1024;
  localparam int          FIFO_DEPTH    = 4;
  localparam logic [10:0] BUF_FULL      = 11'h0400;
  localparam logic [10:0] LEN_RST       = 11'h0000;
  localparam logic [15:0] IDLE_RST      = 16'h0000;
  localparam logic [7:0]  CHAR_RST      = 8'h00;
  localparam logic [7:0]  OFS_LEN       = 8'h00;
  localparam logic [7:0]  OFS_DELIM     = 8'h04;
  localparam logic [7:0]  OFS_IDLE      = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0C;
  localparam int          DLM_EN1_BIT   = 0;
  localparam int          DLM_EN2_BIT   = 1;
  localparam int          DLM_PROC_LSB  = 2;
  localparam int          DLM_C1_LSB    = 8;
  localparam int          DLM_C2_LSB    = 16;
  localparam int          STS_BUSY_BIT  = 16;
  localparam logic [1:0]  FOLLOW_ONE    = 2'h1;
  localparam logic [1:0]  FOLLOW_TWO    = 2'h2;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    PROC_KEEP,
    PROC_PLUS1,
    PROC_PLUS2,
    PROC_STRIP
  } proc_type;

  typedef struct packed {
    logic [10:0] pkt_len;
    logic        dlm1_en;
    logic        dlm2_en;
    proc_type    dlm_proc;
    logic [7:0]  dlm1_char;
    logic [7:0]  dlm2_char;
    logic [15:0] idle_ms;
  } cfg_type;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } word_type;
endpackage

// file: hdl/packet_framer.sv
// Serial packet framer: byte buffer, close logic, FIFO and AHB-Lite regs
// Overview of operation
// - A zero length setting never closes a packet by length.
// - A length of 1 to 1024 closes the packet when the count reaches it.
// - Two delimiters each hold an enable (reset off) and an 8-bit char.
// - Delimiter 1 alone matches one byte; both match the pair in order.
// - With delimiters on, bytes gather until full, length reached, idle timeout or pattern seen.
// - The delimiter treatment (reset keep) acts only with delimiter 1 on.
// - Keep closes on the pattern with the delimiter bytes left in.
// - Plus-one closes after exactly one more byte, which is included.
// - Plus-two closes after exactly two more bytes, which are included.
// - Strip closes on the pattern and drops the delimiter bytes.
// - The idle timer runs since the last byte and restarts on each one.
// - An idle setting of zero never closes a packet by inactivity.
// - An idle setting of 1 to 65535 ms closes what is buffered.
`timescale 1ns/1ps
`default_nettype none

module framer_fifo #(
  parameter int W = 9,
  parameter int D = 4
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic      [W-1:0] o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign o_in_ready  = (cnt_ff != (AW+1)'(D));
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data  = mem_ff[rd_ff];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(D-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(D-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module packet_framer #(
  parameter int MS_CYCLES = framer_pkg::MS_CYCLES
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  output logic             o_rx_ready,
  output logic             o_tx_valid,
  output logic      [7:0]  o_tx_data,
  output logic             o_tx_last,
  input  wire logic        i_tx_ready
);
  typedef enum logic {ST_COLLECT, ST_DRAIN} state_type;

  framer_pkg::cfg_type  cfg_ff;
  framer_pkg::word_type push_word;
  framer_pkg::word_type pop_word;
  framer_pkg::proc_type eff_proc;
  state_type   state_ff;
  logic [7:0]  pkt_mem [framer_pkg::BUF_BYTES];
  logic [10:0] cnt_ff;
  logic [10:0] cnt1;
  logic [10:0] drain_len_ff;
  logic [10:0] nxt_drain_len;
  logic [9:0]  rd_idx_ff;
  logic [1:0]  follow_ff;
  logic [1:0]  nxt_follow;
  logic        match1_ff;
  logic [16:0] div_ff;
  logic [15:0] idle_cnt_ff;
  logic        ms_tick;
  logic        acc;
  logic        hit;
  logic        emit;
  logic        push_valid;
  logic        push_ready;
  logic        pop_valid;
  logic        pop_ready;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic        addr_phase;

  // Bus slave: zero wait states, every answer OKAY
  assign addr_phase = i_hsel && i_hready && (i_htrans == framer_pkg::HTRANS_NONSEQ);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      wr_pend_ff  <= 1'b0;
      wr_addr_ff  <= '0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      wr_pend_ff  <= addr_phase && i_hwrite;
      wr_addr_ff  <= i_haddr[7:0];
    end
  end

  // Read data is staged in the address phase so it stands from a flop
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_hrdata <= '0;
    end else if (addr_phase && !i_hwrite) begin
      o_hrdata <= '0;
      unique case (i_haddr[7:0])
        framer_pkg::OFS_LEN:    o_hrdata[10:0] <= cfg_ff.pkt_len;
        framer_pkg::OFS_DELIM: begin
          o_hrdata[framer_pkg::DLM_EN1_BIT]  <= cfg_ff.dlm1_en;
          o_hrdata[framer_pkg::DLM_EN2_BIT]  <= cfg_ff.dlm2_en;
          o_hrdata[framer_pkg::DLM_PROC_LSB+:2] <= cfg_ff.dlm_proc;
          o_hrdata[framer_pkg::DLM_C1_LSB+:8]   <= cfg_ff.dlm1_char;
          o_hrdata[framer_pkg::DLM_C2_LSB+:8]   <= cfg_ff.dlm2_char;
        end
        framer_pkg::OFS_IDLE:   o_hrdata[15:0] <= cfg_ff.idle_ms;
        framer_pkg::OFS_STATUS: begin
          o_hrdata[10:0] <= cnt_ff;
          o_hrdata[framer_pkg::STS_BUSY_BIT] <= (state_ff == ST_DRAIN);
        end
        default: o_hrdata <= '0;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cfg_ff.pkt_len   <= framer_pkg::LEN_RST;
      cfg_ff.dlm1_en   <= 1'b0;
      cfg_ff.dlm2_en   <= 1'b0;
      cfg_ff.dlm_proc  <= framer_pkg::PROC_KEEP;
      cfg_ff.dlm1_char <= framer_pkg::CHAR_RST;
      cfg_ff.dlm2_char <= framer_pkg::CHAR_RST;
      cfg_ff.idle_ms   <= framer_pkg::IDLE_RST;
    end else if (wr_pend_ff) begin
      unique case (wr_addr_ff)
        framer_pkg::OFS_LEN: begin
          // Lengths above one buffer are clamped to the full size
          if (i_hwdata[10:0] > framer_pkg::BUF_FULL) begin
            cfg_ff.pkt_len <= framer_pkg::BUF_FULL;
          end else begin
            cfg_ff.pkt_len <= i_hwdata[10:0];
          end
        end
        framer_pkg::OFS_DELIM: begin
          cfg_ff.dlm1_en   <= i_hwdata[framer_pkg::DLM_EN1_BIT];
          cfg_ff.dlm2_en   <= i_hwdata[framer_pkg::DLM_EN2_BIT];
          cfg_ff.dlm_proc  <=
            framer_pkg::proc_type'(i_hwdata[framer_pkg::DLM_PROC_LSB+:2]);
          cfg_ff.dlm1_char <= i_hwdata[framer_pkg::DLM_C1_LSB+:8];
          cfg_ff.dlm2_char <= i_hwdata[framer_pkg::DLM_C2_LSB+:8];
        end
        framer_pkg::OFS_IDLE: cfg_ff.idle_ms <= i_hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Close decision
  assign acc      = i_rx_valid && o_rx_ready;
  assign cnt1     = cnt_ff + 11'h001;
  assign eff_proc = cfg_ff.dlm1_en ? cfg_ff.dlm_proc
                                   : framer_pkg::PROC_KEEP;
  assign hit = cfg_ff.dlm1_en && (follow_ff == '0) &&
               (cfg_ff.dlm2_en ? (match1_ff && i_rx_data == cfg_ff.dlm2_char)
                               : (i_rx_data == cfg_ff.dlm1_char));

  always_comb begin
    emit          = 1'b0;
    nxt_drain_len = cnt1;
    nxt_follow    = follow_ff;
    if (acc) begin
      if (follow_ff != '0) begin
        nxt_follow = follow_ff - 2'h1;
        emit       = (follow_ff == framer_pkg::FOLLOW_ONE);
      end else if (hit) begin
        unique case (eff_proc)
          framer_pkg::PROC_KEEP:  emit = 1'b1;
          framer_pkg::PROC_PLUS1: nxt_follow = framer_pkg::FOLLOW_ONE;
          framer_pkg::PROC_PLUS2: nxt_follow = framer_pkg::FOLLOW_TWO;
          framer_pkg::PROC_STRIP: begin
            emit          = 1'b1;
            nxt_drain_len = cfg_ff.dlm2_en ? cnt1 - 11'h002
                                           : cnt1 - 11'h001;
          end
        endcase
      end
      if (cfg_ff.pkt_len != '0 && cnt1 == cfg_ff.pkt_len) begin
        emit = 1'b1;
      end
      if (cnt1 == framer_pkg::BUF_FULL) begin
        emit = 1'b1;
      end
    end else if (state_ff == ST_COLLECT && cnt_ff != '0 &&
                 cfg_ff.idle_ms != '0 && idle_cnt_ff == cfg_ff.idle_ms) begin
      emit          = 1'b1;
      nxt_drain_len = cnt_ff;
    end
  end

  // Store accepted bytes
  always_ff @(posedge i_ref_clk) begin
    if (acc) begin
      pkt_mem[cnt_ff[9:0]] <= i_rx_data;
    end
  end

  // Delimiter pair tracking; a lone first char stays data
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || emit) begin
      match1_ff <= 1'b0;
      follow_ff <= '0;
    end else if (acc) begin
      match1_ff <= (follow_ff == '0) &&
                   (i_rx_data == cfg_ff.dlm1_char);
      follow_ff <= nxt_follow;
    end
  end

  // Millisecond divider and idle counter, both restart on each byte
  assign ms_tick = (div_ff == 17'(MS_CYCLES - 1));

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || acc || emit) begin
      div_ff      <= '0;
      idle_cnt_ff <= '0;
    end else begin
      div_ff <= ms_tick ? '0 : div_ff + 17'h0_0001;
      // Saturate so a long gap cannot wrap back under the setting
      if (ms_tick && idle_cnt_ff != 16'hFFFF) begin
        idle_cnt_ff <= idle_cnt_ff + 16'h0001;
      end
    end
  end

  // Collect and drain sequencing
  assign push_valid     = (state_ff == ST_DRAIN);
  assign push_word.data = pkt_mem[rd_idx_ff];
  assign push_word.last = (11'(rd_idx_ff) == drain_len_ff - 11'h001);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_ff     <= ST_COLLECT;
      cnt_ff       <= '0;
      drain_len_ff <= '0;
      rd_idx_ff    <= '0;
      o_rx_ready   <= 1'b1;
    end else begin
      unique case (state_ff)
        ST_COLLECT: begin
          if (emit) begin
            drain_len_ff <= nxt_drain_len;
            rd_idx_ff    <= '0;
            // A fully stripped packet has nothing to send
            if (nxt_drain_len == '0) begin
              cnt_ff <= '0;
            end else begin
              cnt_ff     <= acc ? cnt1 : cnt_ff;
              state_ff   <= ST_DRAIN;
              o_rx_ready <= 1'b0;
            end
          end else if (acc) begin
            cnt_ff <= cnt1;
          end
        end
        ST_DRAIN: begin
          if (push_ready) begin
            rd_idx_ff <= rd_idx_ff + 10'h001;
            if (push_word.last) begin
              state_ff   <= ST_COLLECT;
              cnt_ff     <= '0;
              o_rx_ready <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  framer_fifo #(
    .W ($bits(framer_pkg::word_type)),
    .D (framer_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_in_valid  (push_valid),
    .i_in_data   (push_word),
    .o_in_ready  (push_ready),
    .o_out_valid (pop_valid),
    .o_out_data  (pop_word),
    .i_out_ready (pop_ready)
  );

  // Output stage keeps the stream ports on flops
  assign pop_ready = !o_tx_valid || i_tx_ready;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_tx_valid <= 1'b0;
      o_tx_data  <= '0;
      o_tx_last  <= 1'b0;
    end else if (pop_ready) begin
      o_tx_valid <= pop_valid;
      o_tx_data  <= pop_word.data;
      o_tx_last  <= pop_word.last;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_len_close: assert property (
    acc && cfg_ff.pkt_len != '0 && cnt1 == cfg_ff.pkt_len
    |=> state_ff == ST_DRAIN && drain_len_ff <= cfg_ff.pkt_len)
    else $error("Length limit did not close the packet");
  chk_len_zero: assert property (
    acc && cfg_ff.pkt_len == '0 && !cfg_ff.dlm1_en &&
    cnt1 != framer_pkg::BUF_FULL |=> state_ff == ST_COLLECT)
    else $error("Packet closed with length zero and no cause");
  chk_full_close: assert property (
    acc && cnt1 == framer_pkg::BUF_FULL |=> state_ff == ST_DRAIN)
    else $error("Full buffer did not close the packet");
  chk_keep_close: assert property (
    acc && hit && eff_proc == framer_pkg::PROC_KEEP
    |=> state_ff == ST_DRAIN && drain_len_ff == $past(cnt1))
    else $error("Keep option closed wrongly");
  chk_strip_len: assert property (
    acc && hit && eff_proc == framer_pkg::PROC_STRIP && cfg_ff.dlm2_en
    && cnt1 > 11'h002 |=> drain_len_ff == $past(cnt1) - 11'h002)
    else $error("Strip did not drop both delimiters");
  chk_plus_two: assert property (
    acc && hit && eff_proc == framer_pkg::PROC_PLUS2 && !emit
    |=> state_ff == ST_COLLECT && follow_ff == framer_pkg::FOLLOW_TWO)
    else $error("Plus-two did not wait for two bytes");
  chk_proc_gate: assert property (
    !cfg_ff.dlm1_en |-> !hit && follow_ff == '0)
    else $error("Delimiter treatment acted while disabled");
  chk_idle_zero: assert property (
    cfg_ff.idle_ms == '0 && !acc |-> !emit)
    else $error("Inactivity close with idle setting zero");
  chk_idle_restart: assert property (
    acc |=> idle_cnt_ff == '0 && div_ff == '0)
    else $error("Idle timer not restarted by a byte");
  chk_drain_block: assert property (
    state_ff == ST_DRAIN |-> !o_rx_ready ##0 !acc)
    else $error("Byte taken while a packet drains");
endmodule

`default_nettype wire

// file: verification/framer_partner.sv
// Partner model: serial byte source and stalling packet sink
`timescale 1ns/1ps
`default_nettype none
module framer_partner (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rx_ready,
  output logic            o_rx_valid,
  output logic      [7:0] o_rx_data,
  output logic            o_tx_ready
);
  logic [7:0] q[$];

  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_tx_ready = 1'b1;
  end

  // A byte stands until taken; the idle line toggles so stale data never looks valid
  always @(posedge i_ref_clk) begin
    if (!(o_rx_valid && !i_rx_ready)) begin
      if (q.size() > 0) begin
        o_rx_valid <= 1'b1;
        o_rx_data  <= q.pop_front();
      end else begin
        o_rx_valid <= 1'b0;
        o_rx_data  <= ~o_rx_data;
      end
    end
  end

  // Random stalls back up the FIFO and hold the drain
  always @(posedge i_ref_clk) begin
    o_tx_ready <= ($urandom % 3) != 0;
  end
endmodule
`default_nettype wire

// file: verification/packet_framer_tb_top.sv
// Self-checking testbench of the serial packet framer
`timescale 1ns/1ps
`default_nettype none
module packet_framer_tb_top;
  logic        i_ref_clk;
  logic        i_rst;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_ready;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_last;
  logic        tx_ready;
  logic [7:0]  b;
  int          failures;
  int          compares;
  int          n;
  int          len;
  framer_pkg::word_type exq[$];

  packet_framer #(.MS_CYCLES(10)) packet_framer_i (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid),
    .o_tx_data(tx_data), .o_tx_last(tx_last), .i_tx_ready(tx_ready));

  framer_partner framer_partner_i (
    .i_ref_clk(i_ref_clk), .i_rx_ready(rx_ready), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .o_tx_ready(tx_ready));

  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Called just after a rising edge; returns just after the data-phase edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= framer_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    @(posedge i_ref_clk);
    while (hready !== 1'b1) @(posedge i_ref_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_ref_clk);
    while (hready !== 1'b1) @(posedge i_ref_clk);
    q = hrdata;
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk(x, e);
  endtask

  function automatic logic [7:0] rnd();
    return 8'h20 + 8'($urandom % 96);
  endfunction

  task automatic sb(input logic [7:0] v, input logic keep, input logic last);
    framer_partner_i.q.push_back(v);
    if (keep) exq.push_back(framer_pkg::word_type'{v, last});
  endtask

  task automatic drain(input string name);
    for (int i = 0; i < 4000 && (exq.size() > 0
         || framer_partner_i.q.size() > 0); i++) @(posedge i_ref_clk);
    repeat (40) @(posedge i_ref_clk);
    chk(32'(exq.size()), 32'h0000_0000);
    $display("test %s done", name);
  endtask

  // Every packet byte handed over is held against the oldest note
  always @(posedge i_ref_clk) begin
    if (!i_rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exq.size() == 0) chk({23'h00_0000, tx_data, tx_last}, 32'h0000_0000);
      else chk({23'h00_0000, tx_data, tx_last}, {23'h00_0000, exq.pop_front()});
    end
  end

  initial begin
    repeat (30000) @(posedge i_ref_clk);
    failures++;
    close_out();
  end

  initial begin
    hsel = 1'b0; htrans = 2'h0; haddr = 32'h0000_0000; hwrite = 1'b0;
    hwdata = 32'h0000_0000; i_rst = 1'b1; failures = 0; compares = 0;
    void'($urandom(76));
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    rd(framer_pkg::OFS_LEN, 32'h0000_0000);
    rd(framer_pkg::OFS_DELIM, 32'h0000_0000);
    rd(framer_pkg::OFS_IDLE, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    wr(framer_pkg::OFS_LEN, 32'h0000_07FF);
    rd(framer_pkg::OFS_LEN, 32'h0000_0400);
    $display("test registers done");
    for (len = 1; len <= 3; len += 2) begin
      wr(framer_pkg::OFS_LEN, 32'(len));
      for (int k = 0; k < 2 * len; k++) sb(rnd(), 1'b1, (k % len) == len - 1);
      drain("length");
    end
    wr(framer_pkg::OFS_LEN, 32'h0000_0000);
    for (int t = 0; t < 4; t++) begin
      n = (t == 1) ? 1 : (t == 2) ? 2 : 0;
      wr(framer_pkg::OFS_DELIM, 32'h0000_0D01 | (32'(t) << 2));
      for (int k = 0; k <= 2 + n; k++) begin
        b = (k == 2) ? 8'h0D : rnd();
        sb(b, !(t == 3 && k == 2), k == 2 + n || (t == 3 && k == 1));
      end
      drain("treatment");
    end
    // A lone first character stays data; only the pair closes
    wr(framer_pkg::OFS_DELIM, 32'h000A_0D03);
    sb(8'h0D, 1'b1, 1'b0);
    sb(rnd(), 1'b1, 1'b0);
    sb(8'h0D, 1'b1, 1'b0);
    sb(8'h0A, 1'b1, 1'b1);
    drain("pair");
    // Strip with the pair drops both delimiter bytes
    wr(framer_pkg::OFS_DELIM, 32'h000A_0D0F);
    sb(rnd(), 1'b1, 1'b1);
    sb(8'h0D, 1'b0, 1'b0);
    sb(8'h0A, 1'b0, 1'b0);
    drain("strip pair");
    wr(framer_pkg::OFS_DELIM, 32'h0000_0D0C);
    sb(rnd(), 1'b1, 1'b0);
    sb(8'h0D, 1'b1, 1'b0);
    repeat (100) @(posedge i_ref_clk);
    chk({31'h0000_0000, tx_valid}, 32'h0000_0000);
    rd(framer_pkg::OFS_STATUS, 32'h0000_0002);
    wr(framer_pkg::OFS_DELIM, 32'h0000_0D01);
    sb(8'h0D, 1'b1, 1'b1);
    drain("disabled");
    // Full buffer and delimiter on the same byte give one packet
    for (int k = 0; k < 1024; k++) sb((k == 1023) ? 8'h0D : rnd(), 1'b1, k == 1023);
    drain("full");
    sb(rnd(), 1'b1, 1'b0);
    sb(8'h0D, 1'b1, 1'b1);
    drain("restart");
    wr(framer_pkg::OFS_DELIM, 32'h0000_0000);
    wr(framer_pkg::OFS_IDLE, 32'h0000_0002);
    sb(rnd(), 1'b1, 1'b0);
    repeat (14) @(posedge i_ref_clk);
    sb(rnd(), 1'b1, 1'b1);
    repeat (16) @(posedge i_ref_clk);
    chk({31'h0000_0000, tx_valid}, 32'h0000_0000);
    drain("idle");
    close_out();
  end
endmodule
`default_nettype wire
